// >>> design/pm_cap_pkg.sv
// Constants for the power management capability register block.
`default_nettype none
package pm_cap_pkg;
   // ==========================================================
   // Bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] OFS_INT_ROUTE = 8'h3C;
   localparam logic [7:0] OFS_CAP_HDR = 8'h80;
   localparam logic [7:0] OFS_PM_CTRL = 8'h84;
   localparam logic [7:0] OFS_IRQ_STAT = 8'hC0;
   localparam logic [7:0] OFS_IRQ_MASK = 8'hC4;

   // ==========================================================
   // Fixed and reset values
   localparam logic [7:0] INT_ROUTE_RST = 8'h00;
   localparam logic [7:0] INT_PIN_VAL = 8'h01;
   localparam logic [7:0] CAP_ID_VAL = 8'h01;
   localparam logic [7:0] NEXT_PTR_VAL = 8'h8C;
   localparam logic [2:0] PM_VERSION_VAL = 3'h3;
   localparam logic PME_CLK_VAL = 1'b0;
   localparam logic AUX_PWR_VAL = 1'b1;
   localparam logic DSI_RST = 1'b0;
   localparam logic [2:0] AUX_CUR_RST = 3'h7;
   localparam logic D1_SUP_RST = 1'b1;
   localparam logic D2_SUP_RST = 1'b1;
   localparam logic [4:0] PME_SUP_RST = 5'h08;
   localparam logic NO_SOFT_RST_RST = 1'b0;
   localparam logic [3:0] DATA_SEL_RST = 4'h0;
   localparam logic [7:0] PM_DATA_VAL = 8'h00;

   // ==========================================================
   // Field positions in the capability header, routing word and control word
   localparam int CAP_ID_LSB = 0;
   localparam int NEXT_PTR_LSB = 8;
   localparam int INT_PIN_LSB = 8;
   localparam int PM_VER_LSB = 16;
   localparam int PME_CLK_BIT = 19;
   localparam int AUX_PWR_BIT = 20;
   localparam int DSI_BIT = 21;
   localparam int AUX_CUR_LSB = 22;
   localparam int D1_SUP_BIT = 25;
   localparam int D2_SUP_BIT = 26;
   localparam int PME_SUP_LSB = 27;
   localparam int PSTATE_LSB = 0;
   localparam int NO_SOFT_RST_BIT = 3;
   localparam int PME_EN_BIT = 8;
   localparam int DATA_SEL_LSB = 9;
   localparam int PME_STAT_BIT = 15;
   localparam int PM_DATA_LSB = 24;

   // ==========================================================
   // Interrupt status bits
   localparam int IRQ_W = 3;
   localparam int IRQ_WAKE_BIT = 0;
   localparam int IRQ_PME_SENT_BIT = 1;
   localparam int IRQ_SOFT_RST_BIT = 2;

   // Power states.
   typedef enum logic [1:0] {
      PS_D0,
      PS_D1,
      PS_D2,
      PS_D3HOT
   } pstate_t;
endpackage : pm_cap_pkg
`default_nettype wire

// >>> design/pm_capability_config_regs.sv
// Power management capability and interrupt routing configuration registers.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
module pm_capability_config_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [pm_cap_pkg::ADDR_W-1:0] addr_i,
   input wire logic [pm_cap_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [pm_cap_pkg::DATA_W-1:0] rdata_o,
   input wire logic autoload_valid_i,
   input wire logic [10:0] autoload_caps_i,
   input wire logic autoload_no_soft_reset_i,
   input wire logic wake_event_i,
   input wire logic pme_sent_i,
   output logic pme_msg_req_o,
   output logic soft_reset_o,
   output logic [1:0] power_state_o,
   output logic irq_o
);
   import pm_cap_pkg::*;

   // ==========================================================
   // Decode helpers
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic wr_route, wr_ctrl, wr_stat, wr_mask;
   assign wr_route = wr_i && hit(addr_i, OFS_INT_ROUTE);
   assign wr_ctrl = wr_i && hit(addr_i, OFS_PM_CTRL);
   assign wr_stat = wr_i && hit(addr_i, OFS_IRQ_STAT);
   assign wr_mask = wr_i && hit(addr_i, OFS_IRQ_MASK);

   // ==========================================================
   // Registers
   logic [7:0] int_route_r;
   pstate_t pstate_r;
   logic pme_en_r;
   logic pme_stat_r;
   logic [3:0] data_sel_r;
   logic dsi_r;
   logic [2:0] aux_cur_r;
   logic d1_sup_r;
   logic d2_sup_r;
   logic [4:0] pme_sup_r;
   logic no_soft_rst_r;
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic [DATA_W-1:0] rdata_r;
   logic pme_req_r;
   logic soft_rst_r;
   logic irq_r;

   // ==========================================================
   // Wake input synchroniser and edge detect
   logic wake_s1_r, wake_s2_r, wake_s3_r;
   logic wake_evt;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wake_s1_r <= 1'b0;
         wake_s2_r <= 1'b0;
         wake_s3_r <= 1'b0;
      end else begin
         wake_s1_r <= wake_event_i;
         wake_s2_r <= wake_s1_r;
         wake_s3_r <= wake_s2_r;
      end
   end

   assign wake_evt = wake_s2_r && !wake_s3_r;

   // ==========================================================
   // Power state and hot reset
   logic hot_reset_req;
   // A D0 write out of D3hot restarts the function internally unless the
   // no-soft-reset flag says that context survives the transition.
   assign hot_reset_req = wr_ctrl && (pstate_r == PS_D3HOT) &&
                          (wdata_i[PSTATE_LSB +: 2] == 2'(PS_D0)) &&
                          !no_soft_rst_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pstate_r <= PS_D0;
      end else if (wr_ctrl) begin
         pstate_r <= pstate_t'(wdata_i[PSTATE_LSB +: 2]);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= hot_reset_req;
      end
   end

   // ==========================================================
   // Interrupt routing byte
   // The internal hot reset returns routing to its reset value as well.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         int_route_r <= INT_ROUTE_RST;
      end else if (soft_rst_r) begin
         int_route_r <= INT_ROUTE_RST;
      end else if (wr_route) begin
         int_route_r <= wdata_i[7:0];
      end
   end

   // ==========================================================
   // PME enable, data select and pending status
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pme_en_r <= 1'b0;
         data_sel_r <= DATA_SEL_RST;
      end else if (wr_ctrl) begin
         pme_en_r <= wdata_i[PME_EN_BIT];
         data_sel_r <= wdata_i[DATA_SEL_LSB +: 4];
      end
   end

   // A wake in the same cycle as the send wins, so no event is lost.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pme_stat_r <= 1'b0;
      end else if (wake_evt && pme_en_r) begin
         pme_stat_r <= 1'b1;
      end else if (pme_sent_i) begin
         pme_stat_r <= 1'b0;
      end
   end

   // The request drops as soon as the sent strobe arrives.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pme_req_r <= 1'b0;
      end else begin
         pme_req_r <= pme_stat_r && pme_en_r && !pme_sent_i;
      end
   end

   // ==========================================================
   // Loadable capability fields
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dsi_r <= DSI_RST;
         aux_cur_r <= AUX_CUR_RST;
         d1_sup_r <= D1_SUP_RST;
         d2_sup_r <= D2_SUP_RST;
         pme_sup_r <= PME_SUP_RST;
         no_soft_rst_r <= NO_SOFT_RST_RST;
      end else if (autoload_valid_i) begin
         dsi_r <= autoload_caps_i[0];
         aux_cur_r <= autoload_caps_i[3:1];
         d1_sup_r <= autoload_caps_i[4];
         d2_sup_r <= autoload_caps_i[5];
         pme_sup_r <= autoload_caps_i[10:6];
         no_soft_rst_r <= autoload_no_soft_reset_i;
      end
   end

   // ==========================================================
   // Interrupt status and mask
   logic [IRQ_W-1:0] irq_set;
   assign irq_set = {soft_rst_r, pme_sent_i && pme_stat_r, wake_evt};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~(wr_stat ? wdata_i[IRQ_W-1:0] : '0)) | irq_set;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_mask_r <= '0;
      end else if (wr_mask) begin
         irq_mask_r <= wdata_i[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ==========================================================
   // Read path
   logic [DATA_W-1:0] cap_word, ctrl_word, route_word, rd_mux;

   always_comb begin
      cap_word = '0;
      cap_word[CAP_ID_LSB +: 8] = CAP_ID_VAL;
      cap_word[NEXT_PTR_LSB +: 8] = NEXT_PTR_VAL;
      cap_word[PM_VER_LSB +: 3] = PM_VERSION_VAL;
      cap_word[PME_CLK_BIT] = PME_CLK_VAL;
      cap_word[AUX_PWR_BIT] = AUX_PWR_VAL;
      cap_word[DSI_BIT] = dsi_r;
      cap_word[AUX_CUR_LSB +: 3] = aux_cur_r;
      cap_word[D1_SUP_BIT] = d1_sup_r;
      cap_word[D2_SUP_BIT] = d2_sup_r;
      cap_word[PME_SUP_LSB +: 5] = pme_sup_r;
   end

   always_comb begin
      ctrl_word = '0;
      ctrl_word[PSTATE_LSB +: 2] = pstate_r;
      ctrl_word[NO_SOFT_RST_BIT] = no_soft_rst_r;
      ctrl_word[PME_EN_BIT] = pme_en_r;
      ctrl_word[DATA_SEL_LSB +: 4] = data_sel_r;
      ctrl_word[PME_STAT_BIT] = pme_stat_r;
      ctrl_word[PM_DATA_LSB +: 8] = PM_DATA_VAL;
   end

   always_comb begin
      route_word = '0;
      route_word[7:0] = int_route_r;
      route_word[INT_PIN_LSB +: 8] = INT_PIN_VAL;
   end

   always_comb begin
      rd_mux = '0;
      case (addr_i)
         OFS_INT_ROUTE: rd_mux = route_word;
         OFS_CAP_HDR: rd_mux = cap_word;
         OFS_PM_CTRL: rd_mux = ctrl_word;
         OFS_IRQ_STAT: rd_mux = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_r};
         OFS_IRQ_MASK: rd_mux = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_r};
         default: rd_mux = '0;
      endcase
   end

   // Read data stand for as many cycles as rd_i was high, then return to zero.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rd_i ? rd_mux : '0;
      end
   end

   assign rdata_o = rdata_r;
   assign pme_msg_req_o = pme_req_r;
   assign soft_reset_o = soft_rst_r;
   assign power_state_o = pstate_r;
   assign irq_o = irq_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_route_write;
      wr_route && !soft_rst_r;
   endsequence

   sequence s_d3_to_d0;
      wr_ctrl && pstate_r == PS_D3HOT && wdata_i[1:0] == 2'b00;
   endsequence

   property p_route_store;
      logic [7:0] v;
      (s_route_write, v = wdata_i[7:0]) |=> int_route_r == v;
   endproperty
   a_route_store: assert property (p_route_store)
      else $error("Routing byte not stored.");

   property p_route_read;
      (rd_i && addr_i == OFS_INT_ROUTE) |=> rdata_o[15:0] == {INT_PIN_VAL, $past(int_route_r)};
   endproperty
   a_route_read: assert property (p_route_read)
      else $error("Routing word read wrong.");

   property p_cap_header;
      (rd_i && addr_i == OFS_CAP_HDR) |=> rdata_o[20:0] == 21'h13_8C01;
   endproperty
   a_cap_header: assert property (p_cap_header)
      else $error("Capability header wrong.");

   property p_cap_loadable;
      (rd_i && addr_i == OFS_CAP_HDR) |=> rdata_o[31:21] ==
         $past({pme_sup_r, d2_sup_r, d1_sup_r, aux_cur_r, dsi_r});
   endproperty
   a_cap_loadable: assert property (p_cap_loadable)
      else $error("Loadable fields wrong.");

   property p_pstate_write;
      wr_ctrl |=> power_state_o == $past(wdata_i[1:0]);
   endproperty
   a_pstate_write: assert property (p_pstate_write)
      else $error("Power state not written.");

   property p_hot_reset;
      s_d3_to_d0 |=> soft_reset_o == !$past(no_soft_rst_r);
   endproperty
   a_hot_reset: assert property (p_hot_reset)
      else $error("Hot reset pulse wrong.");

   property p_hot_reset_cause;
      $rose(soft_reset_o) |-> $past(pstate_r) == PS_D3HOT && power_state_o == PS_D0 &&
         !$past(no_soft_rst_r);
   endproperty
   a_hot_reset_cause: assert property (p_hot_reset_cause)
      else $error("Stray hot reset.");

   property p_pme_gated;
      pme_msg_req_o |-> $past(pme_en_r) && $past(pme_stat_r);
   endproperty
   a_pme_gated: assert property (p_pme_gated)
      else $error("PME request while disabled.");

   property p_pme_pending;
      (wake_evt && pme_en_r) |=> pme_stat_r ##1
         (pme_msg_req_o || $past(pme_sent_i) || !$past(pme_en_r));
   endproperty
   a_pme_pending: assert property (p_pme_pending)
      else $error("Wake not made pending.");

   property p_pme_clear;
      (pme_sent_i && !(wake_evt && pme_en_r)) |=> !pme_stat_r;
   endproperty
   a_pme_clear: assert property (p_pme_clear)
      else $error("Pending not cleared.");

   // The hot reset is a single pulse; routing is back at reset once it ends.
   sequence s_hot_pulse;
      soft_reset_o ##1 (!soft_reset_o && int_route_r == INT_ROUTE_RST);
   endsequence

   property p_hot_pulse;
      (s_d3_to_d0 ##0 !no_soft_rst_r) |=> s_hot_pulse;
   endproperty
   a_hot_pulse: assert property (p_hot_pulse)
      else $error("Hot reset pulse or routing clear wrong.");

   property p_pstate_hold;
      !wr_ctrl |=> $stable(power_state_o);
   endproperty
   a_pstate_hold: assert property (p_pstate_hold)
      else $error("Power state moved without a write.");

   property p_no_soft_ro;
      !autoload_valid_i |=> $stable(no_soft_rst_r);
   endproperty
   a_no_soft_ro: assert property (p_no_soft_ro)
      else $error("No-soft-reset flag changed by software.");

   property p_pme_en_write;
      wr_ctrl |=> pme_en_r == $past(wdata_i[PME_EN_BIT]);
   endproperty
   a_pme_en_write: assert property (p_pme_en_write)
      else $error("PME enable not written.");

   property p_pme_drop;
      pme_sent_i |=> !pme_msg_req_o;
   endproperty
   a_pme_drop: assert property (p_pme_drop)
      else $error("PME request outlived the sent strobe.");

   property p_stat_clear;
      (wr_stat && wdata_i[IRQ_WAKE_BIT] && !wake_evt) |=> !irq_stat_r[IRQ_WAKE_BIT];
   endproperty
   a_stat_clear: assert property (p_stat_clear)
      else $error("Wake status not cleared by a one.");
endmodule : pm_capability_config_regs
`default_nettype wire

// >>> verification/pm_capability_config_regs_tb.sv
// Self-checking testbench of the power management configuration registers.
`timescale 1ns/100ps
`default_nettype none
module pm_capability_config_regs_tb;
   import pm_cap_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   logic autoload_valid_i = 1'b0;
   logic [10:0] autoload_caps_i = 11'h000;
   logic autoload_no_soft_reset_i = 1'b0;
   logic wake_event_i = 1'b0;
   logic pme_sent_i;
   logic pme_msg_req_o;
   logic soft_reset_o;
   logic [1:0] power_state_o;
   logic irq_o;
   logic slow = 1'b0;
   int fail_count = 0;
   int comparisons = 0;
   int pulses = 0;
   logic [31:0] d;
   int p0;

   pm_capability_config_regs pm_capability_config_regs_inst (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .autoload_valid_i(autoload_valid_i),
      .autoload_caps_i(autoload_caps_i), .autoload_no_soft_reset_i(autoload_no_soft_reset_i),
      .wake_event_i(wake_event_i), .pme_sent_i(pme_sent_i), .pme_msg_req_o(pme_msg_req_o),
      .soft_reset_o(soft_reset_o), .power_state_o(power_state_o), .irq_o(irq_o));

   pme_msg_sender_model pme_msg_sender_model_inst (
      .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .pme_msg_req_i(pme_msg_req_o),
      .pme_sent_o(pme_sent_i));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // Counts hot reset pulses so a missing or doubled pulse shows up.
   always @(posedge clk_i) begin
      if (soft_reset_o === 1'b1) pulses++;
   end

   // ==========================================================
   // Shared tasks
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : idle

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask : rd

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk(what, exp, v);
   endtask : rchk

   task automatic wait_req(input logic lvl);
      int i;
      for (i = 0; i < 40 && pme_msg_req_o !== lvl; i++) idle(1);
      if (pme_msg_req_o !== lvl) begin
         fail_count++;
         $display("BAD pme_msg_req_o expected %b seen %b", lvl, pme_msg_req_o);
         final_report();
      end
   endtask : wait_req

   task automatic wake;
      @(posedge clk_i);
      wake_event_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      wake_event_i <= 1'b0;
      idle(3);
   endtask : wake

   // ==========================================================
   // Scenarios
   task automatic t_reset_values;
      rchk("route_pin", OFS_INT_ROUTE, 32'h0000_0100);
      rchk("cap_word", OFS_CAP_HDR, 32'h47D3_8C01);
      rchk("pm_ctrl", OFS_PM_CTRL, 32'h0000_0000);
      rchk("unmapped", 8'h50, 32'h0000_0000);
      rchk("irq_mask", OFS_IRQ_MASK, 32'h0000_0000);
      $display("test reset_values done");
   endtask : t_reset_values

   task automatic t_routing;
      wr(OFS_INT_ROUTE, 32'hFFFF_FFA5);
      rchk("route_rw", OFS_INT_ROUTE, 32'h0000_01A5);
      wr(OFS_CAP_HDR, 32'h0000_0000);
      rchk("cap_ro", OFS_CAP_HDR, 32'h47D3_8C01);
      wr(8'h50, 32'hFFFF_FFFF);
      rchk("unmapped_wr", 8'h50, 32'h0000_0000);
      $display("test routing done");
   endtask : t_routing

   task automatic t_power_state;
      int s;
      for (s = 0; s < 3; s++) begin
         wr(OFS_PM_CTRL, s);
         rchk("pstate", OFS_PM_CTRL, s);
         chk("pstate_o", s, {30'h0, power_state_o});
      end
      wr(OFS_PM_CTRL, 32'hFFFF_FFFF);
      rchk("pm_ctrl_rw", OFS_PM_CTRL, 32'h0000_1F03);
      $display("test power_state done");
   endtask : t_power_state

   task automatic t_hot_reset;
      p0 = pulses;
      wr(OFS_PM_CTRL, 32'h0000_0000);
      idle(3);
      chk("hot_pulses", 1, pulses - p0);
      rchk("route_cleared", OFS_INT_ROUTE, 32'h0000_0100);
      rd(OFS_IRQ_STAT, d);
      chk("stat_hot", 32'h4, d & 32'h4);
      $display("test hot_reset done");
   endtask : t_hot_reset

   task automatic t_pme;
      wr(OFS_IRQ_STAT, 32'h7);
      p0 = 0;
      wake();
      rchk("stat_wake", OFS_IRQ_STAT, 32'h1);
      rchk("no_pending", OFS_PM_CTRL, 32'h0);
      chk("no_req", 0, {31'h0, pme_msg_req_o});
      slow <= 1'b1;
      wr(OFS_PM_CTRL, 32'h100);
      @(posedge clk_i);
      wake_event_i <= 1'b1;
      wait_req(1'b1);
      rchk("pending", OFS_PM_CTRL, 32'h8100);
      wait_req(1'b0);
      rchk("sent_clear", OFS_PM_CTRL, 32'h100);
      rchk("stat_sent", OFS_IRQ_STAT, 32'h3);
      @(posedge clk_i);
      wake_event_i <= 1'b0;
      idle(3);
      @(posedge clk_i);
      wake_event_i <= 1'b1;
      wait_req(1'b1);
      wr(OFS_PM_CTRL, 32'h0);
      idle(1);
      chk("req_dropped", 0, {31'h0, pme_msg_req_o});
      @(posedge clk_i);
      wake_event_i <= 1'b0;
      $display("test pme done");
   endtask : t_pme

   task automatic t_irq;
      idle(2);
      chk("irq_masked", 0, {31'h0, irq_o});
      wr(OFS_IRQ_MASK, 32'h1);
      idle(2);
      chk("irq_on", 1, {31'h0, irq_o});
      rchk("mask_rw", OFS_IRQ_MASK, 32'h1);
      wr(OFS_IRQ_STAT, 32'h1);
      idle(2);
      chk("irq_off", 0, {31'h0, irq_o});
      rchk("stat_w1c", OFS_IRQ_STAT, 32'h2);
      $display("test irq done");
   endtask : t_irq

   task automatic t_autoload;
      @(posedge clk_i);
      autoload_valid_i <= 1'b1;
      autoload_caps_i <= 11'h4B3;
      autoload_no_soft_reset_i <= 1'b1;
      @(posedge clk_i);
      autoload_valid_i <= 1'b0;
      rchk("cap_loaded", OFS_CAP_HDR, 32'h9673_8C01);
      // Pending from the last wake survives the enable being cleared.
      rchk("nsr_loaded", OFS_PM_CTRL, 32'h0000_8008);
      wr(OFS_PM_CTRL, 32'h3);
      p0 = pulses;
      wr(OFS_PM_CTRL, 32'h0);
      idle(3);
      chk("no_hot_pulse", 0, pulses - p0);
      $display("test autoload done");
   endtask : t_autoload

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset_values();
      t_routing();
      t_power_state();
      t_hot_reset();
      t_pme();
      t_irq();
      t_autoload();
      final_report();
   end
endmodule : pm_capability_config_regs_tb
`default_nettype wire

// >>> verification/pme_msg_sender_model.sv
// Behavioural model of the far-side PME message sender.
`timescale 1ns/100ps
`default_nettype none
module pme_msg_sender_model #(
   parameter int SLOW_WAIT = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic pme_msg_req_i,
   output logic pme_sent_o
);
   int cnt_r;
   // ==========================================================
   // Sender
   // A message goes out only while a request stands, after a short or long wait.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 0;
         pme_sent_o <= 1'b0;
      end else begin
         pme_sent_o <= 1'b0;
         if (pme_msg_req_i && !pme_sent_o) begin
            if (cnt_r >= (slow_i ? SLOW_WAIT : 1)) begin
               pme_sent_o <= 1'b1;
               cnt_r <= 0;
            end else begin
               cnt_r <= cnt_r + 1;
            end
         end else begin
            cnt_r <= 0;
         end
      end
   end
endmodule : pme_msg_sender_model
`default_nettype wire
